// ===== design/indicator_pins.sv
// Purpose: Three multipurpose pins: programmable GPIO or LED drivers
// Assumes: PHY status inputs synchronous to CORE_CLK, ACTIVITY a pulse
// Notes:   Pins are split into input, output and active-low output enable
//
// Design decisions made here: strobed register access and the address map.
`default_nettype none
module indicator_pins
  import ledpin_pkg::*;
#(
  parameter int unsigned BLINK_CYCLES = BLINK_CYCLES_DEF
) (
  // Clock, reset, enable
  input wire logic CORE_CLK,
  input wire logic RST_N,
  input wire logic CE,
  // Register port
  input wire logic [ADDR_W-1:0] ADDR,
  input wire logic [DATA_W-1:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [DATA_W-1:0] RDATA,
  // Link status
  input wire logic LINK_UP,
  input wire logic SPEED_100,
  input wire logic AUTONEG_BUSY,
  input wire logic FULL_DUPLEX,
  input wire logic ACTIVITY,
  // Indicator pins
  input wire logic [NUM_PINS-1:0] PIN_IN,
  output logic [NUM_PINS-1:0] PIN_OUT,
  output logic [NUM_PINS-1:0] PIN_OE_N
);

  // ******************************************************
  // Helpers
  // ******************************************************
  localparam logic [CNT_W-1:0] BLINK_LAST = CNT_W'(BLINK_CYCLES - 1);

  // Returns {out, oe_n} for one pin
  function automatic logic [1:0] pin_drive(input logic led, input logic lvl,
                                           input logic dir, input logic od,
                                           input logic dout);
    logic [1:0] r;
    r = 2'b01;
    if (led) begin
      r = {1'b0, lvl};
    end else if (dir && od) begin
      r = {1'b0, dout};
    end else if (dir) begin
      r = {dout, 1'b0};
    end
    return r;
  endfunction

  // Decode shared by the write and read paths
  function automatic logic reg_hit(input logic stb,
                                   input logic [ADDR_W-1:0] a,
                                   input logic [ADDR_W-1:0] ofs);
    return stb && a == ofs;
  endfunction

  // ******************************************************
  // Configuration register
  // ******************************************************
  logic [DATA_W-1:0] cfg_q;
  logic [NUM_PINS-1:0] dout, dir, odrain, led_en;
  assign dout = cfg_q[CFG_DOUT_LSB +: NUM_PINS];
  assign dir = cfg_q[CFG_DIR_LSB +: NUM_PINS];
  assign odrain = cfg_q[CFG_ODRAIN_LSB +: NUM_PINS];
  assign led_en = cfg_q[CFG_LED_LSB +: NUM_PINS];

  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      cfg_q <= CFG_RESET;
    end else if (CE && reg_hit(WR, ADDR, CFG_OFS)) begin
      cfg_q <= '0;
      cfg_q[CFG_DOUT_LSB +: NUM_PINS] <= WDATA[CFG_DOUT_LSB +: NUM_PINS];
      cfg_q[CFG_DIR_LSB +: NUM_PINS] <= WDATA[CFG_DIR_LSB +: NUM_PINS];
      cfg_q[CFG_ODRAIN_LSB +: NUM_PINS] <=
        WDATA[CFG_ODRAIN_LSB +: NUM_PINS];
      cfg_q[CFG_LED_LSB +: NUM_PINS] <= WDATA[CFG_LED_LSB +: NUM_PINS];
    end
  end

  // ******************************************************
  // Activity blink sequencer
  // ******************************************************
  act_state_t act_q;
  logic [CNT_W-1:0] cnt_q;
  logic pend_q;

  // Activity seen while held low is remembered for the next blink
  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      act_q <= ACT_LIT;
      cnt_q <= '0;
      pend_q <= 1'b0;
    end else if (CE) begin
      if (!LINK_UP) begin
        act_q <= ACT_LIT;
        cnt_q <= '0;
        pend_q <= 1'b0;
      end else begin
        case (act_q)
          ACT_LIT: begin
            cnt_q <= '0;
            if (ACTIVITY) begin
              act_q <= ACT_DARK;
            end
          end
          ACT_DARK: begin
            // Activity here is ignored so the pulse is never stretched
            if (cnt_q == BLINK_LAST) begin
              cnt_q <= '0;
              act_q <= ACT_HOLD;
            end else begin
              cnt_q <= cnt_q + 1'b1;
            end
          end
          ACT_HOLD: begin
            if (ACTIVITY) begin
              pend_q <= 1'b1;
            end
            if (cnt_q == BLINK_LAST) begin
              cnt_q <= '0;
              pend_q <= 1'b0;
              act_q <= (pend_q || ACTIVITY) ? ACT_DARK : ACT_LIT;
            end else begin
              cnt_q <= cnt_q + 1'b1;
            end
          end
          default: begin
            act_q <= ACT_LIT;
            cnt_q <= '0;
          end
        endcase
      end
    end
  end

  // ******************************************************
  // Indicator levels
  // ******************************************************
  logic speed_ind_q, act_ind_q, duplex_ind_q;
  logic [NUM_PINS-1:0] ind;
  assign ind[SPEED_PIN] = speed_ind_q;
  assign ind[ACT_PIN] = act_ind_q;
  assign ind[DUPLEX_PIN] = duplex_ind_q;

  // High in reset, otherwise only at a settled 10 Mbs link
  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      speed_ind_q <= 1'b1;
    end else if (CE) begin
      speed_ind_q <= LINK_UP && !SPEED_100 && !AUTONEG_BUSY;
    end
  end

  // Dark while a blink runs or whenever the link is down
  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      act_ind_q <= 1'b1;
    end else if (CE) begin
      act_ind_q <= !(LINK_UP && act_q != ACT_DARK);
    end
  end

  // Released whenever the link is down, whatever the duplex input says
  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      duplex_ind_q <= 1'b1;
    end else if (CE) begin
      duplex_ind_q <= !(LINK_UP && FULL_DUPLEX);
    end
  end

  // ******************************************************
  // Pin drivers
  // ******************************************************
  // One cycle behind the settings, traded for flop-driven pins
  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      PIN_OUT <= '0;
      PIN_OE_N <= '1;
    end else if (CE) begin
      for (int i = 0; i < NUM_PINS; i++) begin
        {PIN_OUT[i], PIN_OE_N[i]} <=
          pin_drive(led_en[i], ind[i], dir[i], odrain[i], dout[i]);
      end
    end
  end

  // ******************************************************
  // Register read
  // ******************************************************
  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      RDATA <= '0;
    end else if (CE) begin
      RDATA <= '0;
      if (reg_hit(RD, ADDR, CFG_OFS)) begin
        RDATA <= cfg_q;
      end else if (reg_hit(RD, ADDR, STAT_OFS)) begin
        RDATA[STAT_PIN_LSB +: NUM_PINS] <= PIN_IN;
        RDATA[STAT_IND_LSB +: NUM_PINS] <= ind;
      end
    end
  end

endmodule // indicator_pins
`default_nettype wire

// ===== design/ledpin_pkg.sv
// Purpose: Shared constants for the multipurpose pin and indicator block
// Assumes: 100 MHz core clock, 32-bit register port
// Notes:   Register offsets are byte addresses
`default_nettype none
package ledpin_pkg;
  // ******************************************************
  // Sizes and timing
  // ******************************************************
  localparam int NUM_PINS = 3;
  localparam int DATA_W = 32;
  localparam int ADDR_W = 8;
  localparam int CLK_FREQ_KHZ = 100000;
  localparam int BLINK_TIME_MS = 80;
  localparam int BLINK_CYCLES_DEF = BLINK_TIME_MS * CLK_FREQ_KHZ;
  localparam int CNT_W = 24;

  // ******************************************************
  // Register map
  // ******************************************************
  localparam logic [ADDR_W-1:0] CFG_OFS = 8'h00;
  localparam logic [ADDR_W-1:0] STAT_OFS = 8'h04;
  // Field bases inside the configuration register
  localparam int CFG_DOUT_LSB = 0;
  localparam int CFG_DIR_LSB = 4;
  localparam int CFG_ODRAIN_LSB = 8;
  localparam int CFG_LED_LSB = 12;
  // Field bases inside the status register
  localparam int STAT_PIN_LSB = 0;
  localparam int STAT_IND_LSB = 4;
  localparam logic [DATA_W-1:0] CFG_RESET = 32'h0000_0000;

  // Pin to indicator assignment
  localparam int SPEED_PIN = 0;
  localparam int ACT_PIN = 1;
  localparam int DUPLEX_PIN = 2;

  // ******************************************************
  // Activity blink states
  // ******************************************************
  typedef enum logic [1:0] {
    ACT_LIT = 2'b00,
    ACT_DARK = 2'b01,
    ACT_HOLD = 2'b11
  } act_state_t;
endpackage
`default_nettype wire

// ===== test/indicator_pins_props.sv
// Purpose: Port checks for the indicator pin block
// Assumes: Checks pause while CE is low
// Notes:   Shadows the config word from the write port
`default_nettype none
module pin_props
  import ledpin_pkg::*;
#(parameter int unsigned BLINK_CYCLES = 8) (
  // Clock and reset
  input wire logic CORE_CLK,
  input wire logic RST_N,
  input wire logic CE,
  // Register port
  input wire logic [ADDR_W-1:0] ADDR,
  input wire logic [DATA_W-1:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  input wire logic [DATA_W-1:0] RDATA,
  // Status and pins
  input wire logic LINK_UP,
  input wire logic SPEED_100,
  input wire logic AUTONEG_BUSY,
  input wire logic FULL_DUPLEX,
  input wire logic [NUM_PINS-1:0] PIN_IN,
  input wire logic [NUM_PINS-1:0] PIN_OUT,
  input wire logic [NUM_PINS-1:0] PIN_OE_N
);
  timeunit 1ns;
  timeprecision 1ns;
  localparam int B1 = BLINK_CYCLES - 1;
  logic [CFG_LED_LSB+NUM_PINS-1:0] cfg_q;
  logic [NUM_PINS-1:0] dout, dir, od, led;
  assign dout = cfg_q[CFG_DOUT_LSB +: NUM_PINS];
  assign dir = cfg_q[CFG_DIR_LSB +: NUM_PINS];
  assign od = cfg_q[CFG_ODRAIN_LSB +: NUM_PINS];
  assign led = cfg_q[CFG_LED_LSB +: NUM_PINS];
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (!RST_N || !CE);
  // Shadow of the configuration word, frozen like the block when CE is low
  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      cfg_q <= '0;
    end else if (CE && WR && ADDR == CFG_OFS) begin
      cfg_q <= WDATA[CFG_LED_LSB+NUM_PINS-1:0];
    end
  end
  // ****************
  // Checks
  // ****************
  sequence dark_s; PIN_OE_N[1] throughout (##B1 1'b1); endsequence
  sequence lit_s; !PIN_OE_N[1] throughout (##B1 1'b1); endsequence
  stat_pins_a: assert property (RD && ADDR == STAT_OFS |=>
    RDATA[2:0] == $past(PIN_IN)) else $error("pin levels not read");
  speed_led_a: assert property ($past(led[0]) |-> !PIN_OUT[0] &&
    PIN_OE_N[0] == $past(LINK_UP && !SPEED_100 && !AUTONEG_BUSY, 2))
    else $error("speed pin wrong");
  duplex_led_a: assert property ($past(led[2]) |-> !PIN_OUT[2] &&
    PIN_OE_N[2] == !$past(LINK_UP && FULL_DUPLEX, 2))
    else $error("duplex pin wrong");
  led_no_high_a: assert property (
    (~PIN_OE_N & PIN_OUT & $past(led)) == '0) else $error("led drove high");
  push_pull_a: assert property (
    $past(dir[0] && !od[0] && !led[0]) |->
    !PIN_OE_N[0] && PIN_OUT[0] == $past(dout[0])) else $error("push-pull");
  open_drain_a: assert property (
    $past(dir[0] && od[0] && !led[0]) |->
    !PIN_OUT[0] && PIN_OE_N[0] == $past(dout[0])) else $error("open drain");
  input_mode_a: assert property ($past(!dir[1] && !led[1]) |->
    PIN_OE_N[1]) else $error("input pin driven");
  blink_time_a: assert property (
    $rose(PIN_OE_N[1]) && $past(led[1]) && $past(LINK_UP, 2) |->
    dark_s ##1 lit_s) else $error("blink timing");
endmodule // pin_props
bind indicator_pins pin_props #(.BLINK_CYCLES(BLINK_CYCLES)) u_props (
  .CORE_CLK, .RST_N, .CE, .ADDR, .WDATA, .WR, .RD, .RDATA, .LINK_UP,
  .SPEED_100,
  .AUTONEG_BUSY, .FULL_DUPLEX, .PIN_IN, .PIN_OUT, .PIN_OE_N);
`default_nettype wire

// ===== test/pin_board.sv
// Purpose: Board model of the three pins with pull-ups
// Assumes: Released pins float high
// Notes:   EXT_N lets the board pull a pin low
`default_nettype none
module pin_board
  import ledpin_pkg::*;
(
  // Design side
  input wire logic [NUM_PINS-1:0] PIN_OUT,
  input wire logic [NUM_PINS-1:0] PIN_OE_N,
  // Board side
  input wire logic [NUM_PINS-1:0] EXT_N,
  output logic [NUM_PINS-1:0] PIN_IN
);
  timeunit 1ns;
  timeprecision 1ns;
  // Pull-up on release, so a floating pin never shows a stale level
  assign PIN_IN = (PIN_OE_N | PIN_OUT) & EXT_N;
endmodule // pin_board
`default_nettype wire

// ===== test/tb_indicator_pins.sv
// Purpose: Self-checking bench for the indicator pin block
// Assumes: Pull-ups on all pins
// Notes:   Short blink count keeps the run brief
`default_nettype none
module tb_indicator_pins;
  import ledpin_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int unsigned BL = 8;
  logic clk = 1'b0, rst_n = 1'b0, wr = 1'b0, rd = 1'b0, act = 1'b0;
  logic link = 1'b0, s100 = 1'b0, aneg = 1'b0, fdx = 1'b0;
  logic [ADDR_W-1:0] addr = '0;
  logic [DATA_W-1:0] wdata = '0, rdata, d;
  logic [NUM_PINS-1:0] p_in, p_out, p_oe_n, ext_n = '1;
  logic ce = 1'b1;
  int n_errors = 0, n_compared = 0;
  logic [31:0] n;
  indicator_pins #(.BLINK_CYCLES(BL)) DUT (.CORE_CLK(clk), .RST_N(rst_n),
    .CE(ce), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata),
    .LINK_UP(link), .SPEED_100(s100), .AUTONEG_BUSY(aneg),
    .FULL_DUPLEX(fdx), .ACTIVITY(act), .PIN_IN(p_in), .PIN_OUT(p_out),
    .PIN_OE_N(p_oe_n));
  pin_board board (.PIN_OUT(p_out), .PIN_OE_N(p_oe_n), .EXT_N(ext_n),
    .PIN_IN(p_in));
  initial begin
    forever #5 clk = ~clk;
  end
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    n_compared++;
    if (s !== e) begin
      n_errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task automatic wr32(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= v;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd32(input logic [7:0] a);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask
  task automatic t_gpio();
    ext_n <= 3'b101;
    wr32(CFG_OFS, 32'h0000_0011);
    rd32(STAT_OFS);
    chk(d[2:0], 3'b101);
    wr32(CFG_OFS, 32'h0000_0110);
    rd32(CFG_OFS);
    chk(d, 32'h0000_0110);
    rd32(STAT_OFS);
    chk(d[2:0], 3'b100);
    rd32(8'h08);
    chk(d, '0);
    @(posedge clk);
    ext_n <= '1;
  endtask
  task automatic t_freeze();
    // A write with CE low, one to an unmapped offset, then reserved bits
    ce <= 1'b0;
    wr32(CFG_OFS, 32'h0000_7077);
    ce <= 1'b1;
    rd32(CFG_OFS);
    chk(d, 32'h0000_0110);
    wr32(8'h08, 32'h0000_7077);
    rd32(CFG_OFS);
    chk(d, 32'h0000_0110);
    wr32(CFG_OFS, 32'hffff_8888);
    rd32(CFG_OFS);
    chk(d, 32'h0000_0000);
  endtask
  task automatic t_leds();
    logic [2:0] e;
    // Direction and value bits set on purpose: LED mode must mask them
    wr32(CFG_OFS, 32'h0000_7077);
    for (int i = 0; i < 16; i++) begin
      @(posedge clk);
      {fdx, link, s100, aneg} <= i[3:0];
      repeat (4) @(posedge clk);
      rd32(STAT_OFS);
      e = {!(link && fdx), !link, link && !s100 && !aneg};
      chk(d[6:0], {e, 1'b0, e});
    end
  endtask
  task automatic t_blink(input int a, input int exp);
    n = 0;
    for (int k = 0; k < 40; k++) begin
      @(posedge clk);
      act <= (k == 0 || k == a);
      #1 n += p_in[1];
    end
    chk(n, exp);
  endtask
  task automatic close_out();
    $display("Errors %0d, compares %0d", n_errors, n_compared);
    if (n_errors == 0 && n_compared > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  initial begin
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    t_gpio();
    t_freeze();
    t_leds();
    t_blink(4, BL);
    t_blink(13, 2 * BL);
    close_out();
  end
  initial begin
    #20000;
    n_errors++;
    close_out();
  end
endmodule // tb_indicator_pins
`default_nettype wire
